//--- gprc_ctrl_model.sv
/*
 * Behavioural model of the bus controller that faces the port: it drives
 * REN, ATN and the decoded one-cycle bus event pulses, and takes the byte
 * stream with an optional stall. Assumes one clock shared with the block.
 */
module gprc_ctrl_model (
	input wire logic pclk,
	output logic ren,
	output logic atn,
	output logic lads_evt,
	output logic unl_evt,
	output logic tads_evt,
	output logic unt_evt,
	output logic get_evt,
	output logic gtl_evt,
	output logic llo_evt,
	output logic rx_data_evt,
	input wire logic [7:0] out_byte,
	input wire logic out_valid,
	input wire logic out_eoi,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ev;
	logic stall;
	logic tog;
	logic [8:0] rxq[$];
	// ************
	// Bus side
	// ************
	// One-hot event vector, bit order matches the mask constants of the bench.
	assign {rx_data_evt, llo_evt, gtl_evt, get_evt, unt_evt, tads_evt, unl_evt, lads_evt} = ev;
	// A stalling sink only takes every other cycle, so held bytes are exercised.
	assign out_ready = !stall || tog;
	initial begin
		ren = 1'b0;
		atn = 1'b1;
		ev = 8'h00;
		stall = 1'b0;
		tog = 1'b0;
	end
	always @(posedge pclk) begin
		tog <= !tog;
	end
	// Each byte the sink takes is queued with its EOI flag, which marks the closing LF.
	always @(posedge pclk) begin
		if (out_valid === 1'b1 && out_ready) begin
			rxq.push_back({out_eoi, out_byte});
		end
	end
	// Events are one-cycle pulses, then a settle time; ATN is left at its level.
	task automatic pulse(input logic [7:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 8'h00;
		repeat (3) @(posedge pclk);
	endtask
	task automatic lines(input logic r, input logic a);
		@(posedge pclk);
		ren <= r;
		atn <= a;
		repeat (3) @(posedge pclk);
	endtask
	// Talk-address first, then release ATN so the device may become talker.
	task automatic talk_read();
		pulse(8'h04);
		lines(ren, 1'b0);
	endtask
endmodule

//--- gprc_pkg.sv
/*
 * Constants for the remote/local and output-mode controller of an
 * instrument bus port. Assumes one 200 MHz clock and an APB master.
 */
package gprc_pkg;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_TXD = 8'h10;
	localparam logic [4:0] ADDR_MAX = 5'h1E;
	localparam logic [4:0] ADDR_RST = 5'h04;
	localparam logic [4:0] PLOT_RST = 5'h05;
	// CTRL bits.
	localparam int CTRL_SRQ_EN = 0;
	localparam int CTRL_EMUL = 1;
	// CMD bits: mode field, load strobe, update-now, clear error.
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_MODE_LD = 4;
	localparam int CMD_UPDATE_DATA_NOW_CMD = 5;
	localparam int CMD_ERR_CLR = 6;
	localparam int TXD_LAST = 8;
	localparam logic [7:0] CHR_CR = 8'h0D;
	localparam logic [7:0] CHR_LF = 8'h0A;
	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_PS = 5000;
	localparam int SELF_CHECK_NS = 10000;
	localparam int SELF_CHECK_CYC = (SELF_CHECK_NS * 1000 + CLK_PS - 1) / CLK_PS;
	typedef enum logic [2:0] {
		MODE_TRIG = 3'b000,
		MODE_CONT = 3'b001,
		MODE_PLOT = 3'b010,
		MODE_TEMP = 3'b011,
		MODE_STAT = 3'b100,
		MODE_SAPL = 3'b101
	} gprc_mode_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DATA = 2'b01,
		TX_CR = 2'b10,
		TX_LF = 2'b11
	} gprc_tx_e;
endpackage

//--- gprc_top.sv
/*
 * Remote/local state, lockout, output-mode sequencing and output byte
 * stream for the bus port. Assumes an interface chip that decodes bus
 * addressing and commands into one-cycle pulses, and firmware that writes
 * measurement characters over APB. Non-volatile addresses arrive as inputs.
 */
// The implementer's own choices: the APB interface to the registers and the register addresses.
module gprc_top #(
	parameter int SELF_CHECK = gprc_pkg::SELF_CHECK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ren,
	input wire logic atn,
	input wire logic lads_evt,
	input wire logic unl_evt,
	input wire logic tads_evt,
	input wire logic unt_evt,
	input wire logic get_evt,
	input wire logic gtl_evt,
	input wire logic llo_evt,
	input wire logic rx_data_evt,
	input wire logic key_menu,
	input wire logic key_one,
	input wire logic key_two,
	input wire logic key_other,
	input wire logic meas_trig,
	input wire logic [4:0] nv_own_addr,
	input wire logic [4:0] nv_plot_addr,
	output logic [4:0] own_addr,
	output logic nv_write,
	output logic remote,
	output logic llo_lamp,
	output logic prompt,
	output logic emulation,
	output logic srq,
	output logic abort_act,
	output logic [7:0] out_byte,
	output logic out_valid,
	output logic out_eoi,
	input wire logic out_ready
);
	// ********************************************************
	// Power-up self check
	// ********************************************************
	logic [15:0] chk_cnt_q;
	logic [4:0] plot_addr_q;
	logic [7:0] tx_byte_q;
	logic ready_q, srq_en_q, remote_q, llo_q, listened_q, talked_q;
	logic tacs_q, armed_q, data_rdy_q, done_q, err_q, tx_last_q;
	gprc_pkg::gprc_mode_e mode_q, base_q;
	gprc_pkg::gprc_tx_e tx_q;
	logic wr_acc, rd_set, bus_ok, tacs_d, self_term;
	logic sapl_end, wr_cmd, wr_txd, tx_ok, tx_fin;
	// The bus side stays deaf until the check ends and the setup is restored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_cnt_q <= 16'h0000;
			ready_q <= 1'b0;
		end else if (!ready_q) begin
			if (chk_cnt_q == 16'(SELF_CHECK - 1)) begin
				ready_q <= 1'b1;
			end
			chk_cnt_q <= chk_cnt_q + 16'h0001;
		end
	end
	// ********************************************************
	// APB slave
	// ********************************************************
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_set = psel & !penable;
	assign wr_cmd = wr_acc & (paddr == gprc_pkg::OFS_CMD);
	assign wr_txd = wr_acc & (paddr == gprc_pkg::OFS_TXD);

	// Answer is ready one cycle after setup, so every access has no wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= rd_set;
			pslverr <= rd_set & (paddr > gprc_pkg::OFS_TXD | paddr[1:0] != 2'b00);
			if (rd_set) begin
				unique case (paddr)
					gprc_pkg::OFS_CTRL: prdata <= {30'h0, emulation, srq_en_q};
					gprc_pkg::OFS_ADDR: prdata <= {19'h0, plot_addr_q, 3'h0, own_addr};
					gprc_pkg::OFS_STAT: prdata <= {19'h0, tx_q, mode_q, err_q, done_q,
						data_rdy_q, armed_q, tacs_q, llo_q, prompt, remote_q};
					gprc_pkg::OFS_CMD: prdata <= {29'h0, base_q};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Control bits; emulation always comes up off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srq_en_q <= 1'b0;
			emulation <= 1'b0;
		end else if (wr_acc & (paddr == gprc_pkg::OFS_CTRL)) begin
			srq_en_q <= pwdata[gprc_pkg::CTRL_SRQ_EN];
			emulation <= pwdata[gprc_pkg::CTRL_EMUL];
		end
	end

	// Addresses load from the store after the check; out-of-range writes are
	// dropped so 31, which is not a bus address, is never written to the store.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_addr <= gprc_pkg::ADDR_RST;
			plot_addr_q <= gprc_pkg::PLOT_RST;
			nv_write <= 1'b0;
		end else begin
			nv_write <= 1'b0;
			if (!ready_q && chk_cnt_q == 16'(SELF_CHECK - 1)) begin
				if (nv_own_addr <= gprc_pkg::ADDR_MAX) own_addr <= nv_own_addr;
				if (nv_plot_addr <= gprc_pkg::ADDR_MAX) plot_addr_q <= nv_plot_addr;
			end else if (wr_acc && paddr == gprc_pkg::OFS_ADDR &&
				pwdata[4:0] <= gprc_pkg::ADDR_MAX &&
				pwdata[12:8] <= gprc_pkg::ADDR_MAX) begin
				own_addr <= pwdata[4:0];
				plot_addr_q <= pwdata[12:8];
				nv_write <= 1'b1;
			end
		end
	end
	// ********************************************************
	// Remote, local and lockout
	// ********************************************************
	// Bus events count only after the check and outside the escape prompt.
	assign bus_ok = ready_q & !prompt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_q <= 1'b0;
			prompt <= 1'b0;
		end else if (!ren) begin
			remote_q <= 1'b0;
			prompt <= 1'b0;
		end else if (prompt) begin
			if (key_one) begin
				remote_q <= 1'b0;
				prompt <= 1'b0;
			end else if (key_two) begin
				prompt <= 1'b0;
			end
		end else if (bus_ok & gtl_evt) begin
			remote_q <= 1'b0;
		end else if (bus_ok & lads_evt) begin
			remote_q <= 1'b1;
		end else if (remote_q & !llo_q & key_menu) begin
			prompt <= 1'b1;
		end
	end

	// Lockout lamp waits for the next address change or keystroke.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			llo_q <= 1'b0;
			llo_lamp <= 1'b0;
		end else if (!ren) begin
			llo_q <= 1'b0;
			llo_lamp <= 1'b0;
		end else begin
			if (bus_ok & llo_evt & remote_q) llo_q <= 1'b1;
			if (llo_q & (lads_evt | unl_evt | tads_evt | unt_evt |
				key_menu | key_one | key_two | key_other)) begin
				llo_lamp <= 1'b1;
			end
		end
	end
	assign remote = remote_q;
	// ********************************************************
	// Addressed state and talker active
	// ********************************************************
	assign self_term = mode_q inside {gprc_pkg::MODE_PLOT, gprc_pkg::MODE_TEMP,
		gprc_pkg::MODE_STAT, gprc_pkg::MODE_SAPL};
	assign sapl_end = tx_fin & (mode_q == gprc_pkg::MODE_SAPL);
	assign tacs_d = talked_q & !atn & remote_q & !prompt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			listened_q <= 1'b0;
			talked_q <= 1'b0;
			tacs_q <= 1'b0;
		end else begin
			tacs_q <= tacs_d;
			if (bus_ok & lads_evt) listened_q <= 1'b1;
			else if (bus_ok & unl_evt) listened_q <= 1'b0;
			if ((bus_ok & unt_evt) | sapl_end | !remote_q) talked_q <= 1'b0;
			else if (bus_ok & tads_evt & remote_q) talked_q <= 1'b1;
		end
	end
	// ********************************************************
	// Output mode and trigger reset
	// ********************************************************
	// Untalk falls back to the last of trigger-reset or continuous.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= gprc_pkg::MODE_TRIG;
			base_q <= gprc_pkg::MODE_TRIG;
			done_q <= 1'b0;
		end else if ((bus_ok & unt_evt) | sapl_end) begin
			mode_q <= base_q;
			done_q <= 1'b0;
		end else if (wr_cmd & remote_q & pwdata[gprc_pkg::CMD_MODE_LD] &
			pwdata[2:0] <= 3'b101) begin
			mode_q <= gprc_pkg::gprc_mode_e'(pwdata[2:0]);
			if (pwdata[2:1] == 2'b00) base_q <= gprc_pkg::gprc_mode_e'(pwdata[2:0]);
			done_q <= 1'b0;
		end else if (tx_fin & self_term) begin
			done_q <= 1'b1;
		end
	end

	// Arm on a trigger reset; continuous mode arms on entering talk.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
			data_rdy_q <= 1'b0;
			abort_act <= 1'b0;
		end else begin
			abort_act <= armed_q & ((bus_ok & unt_evt) | wr_cmd);
			if (armed_q & ((bus_ok & unt_evt) | (wr_cmd & !pwdata[gprc_pkg::CMD_UPDATE_DATA_NOW_CMD]))) begin
				armed_q <= 1'b0;
			end else if (wr_cmd & remote_q & pwdata[gprc_pkg::CMD_UPDATE_DATA_NOW_CMD]) begin
				armed_q <= 1'b0;
				data_rdy_q <= 1'b1;
			end else if (bus_ok & get_evt & listened_q & remote_q) begin
				armed_q <= 1'b1;
				data_rdy_q <= 1'b0;
			end else if (tacs_d & !tacs_q & mode_q == gprc_pkg::MODE_CONT) begin
				armed_q <= 1'b1;
			end else if (armed_q & meas_trig) begin
				armed_q <= mode_q == gprc_pkg::MODE_CONT;
				data_rdy_q <= 1'b1;
			end else if (tx_fin & !self_term) begin
				data_rdy_q <= 1'b0;
			end
		end
	end
	// ********************************************************
	// Error and service request
	// ********************************************************
	// A new error outranks a clear written in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0;
		end else if (bus_ok & !remote_q & (listened_q | talked_q) &
			(get_evt | rx_data_evt)) begin
			err_q <= 1'b1;
		end else if (wr_cmd & pwdata[gprc_pkg::CMD_ERR_CLR]) begin
			err_q <= 1'b0;
		end
	end

	// Talker active clears a pending request, even if one arrives with it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srq <= 1'b0;
		end else if (!srq_en_q | tacs_q) begin
			srq <= 1'b0;
		end else if ((armed_q & meas_trig) |
			(wr_cmd & remote_q & pwdata[gprc_pkg::CMD_UPDATE_DATA_NOW_CMD]) |
			(bus_ok & !remote_q & (listened_q | talked_q) & (get_evt | rx_data_evt))) begin
			srq <= 1'b1;
		end
	end
	// ********************************************************
	// Output byte stream
	// ********************************************************
	// Firmware may hand over a byte only when the mode permits sending.
	assign tx_ok = tacs_q & remote_q & !done_q &
		(self_term | data_rdy_q);
	assign tx_fin = (tx_q == gprc_pkg::TX_LF) & out_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= gprc_pkg::TX_IDLE;
			tx_byte_q <= 8'h00;
			tx_last_q <= 1'b0;
		end else begin
			unique case (tx_q)
				gprc_pkg::TX_IDLE: if (wr_txd & tx_ok) begin
					tx_byte_q <= pwdata[7:0];
					tx_last_q <= pwdata[gprc_pkg::TXD_LAST];
					tx_q <= gprc_pkg::TX_DATA;
				end
				gprc_pkg::TX_DATA: if (!tacs_q) begin
					tx_q <= gprc_pkg::TX_IDLE;
				end else if (out_ready) begin
					tx_q <= tx_last_q ? gprc_pkg::TX_CR : gprc_pkg::TX_IDLE;
				end
				gprc_pkg::TX_CR: if (!tacs_q) begin
					tx_q <= gprc_pkg::TX_IDLE;
				end else if (out_ready) begin
					tx_q <= gprc_pkg::TX_LF;
				end
				gprc_pkg::TX_LF: if (out_ready | !tacs_q) begin
					tx_q <= gprc_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// Byte, strobe and EOI are registered from the next state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_byte <= 8'h00;
			out_valid <= 1'b0;
			out_eoi <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			out_eoi <= 1'b0;
			if (tx_q == gprc_pkg::TX_IDLE & wr_txd & tx_ok) begin
				out_byte <= pwdata[7:0];
				out_valid <= 1'b1;
			end else if (tx_q == gprc_pkg::TX_DATA & tacs_q) begin
				out_valid <= !out_ready | tx_last_q;
				if (out_ready & tx_last_q) out_byte <= gprc_pkg::CHR_CR;
			end else if (tx_q == gprc_pkg::TX_CR & tacs_q) begin
				out_valid <= 1'b1;
				if (out_ready) begin
					out_byte <= gprc_pkg::CHR_LF;
					out_eoi <= 1'b1;
				end
			end else if (tx_q == gprc_pkg::TX_LF & tacs_q & !out_ready) begin
				out_valid <= 1'b1;
				out_eoi <= 1'b1;
			end
		end
	end
	// ********************************************************
	// Checks
	// ********************************************************
	ren_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ren |=> !remote_q) else $error("remote held without REN");
	enter_remote_a: assert property (@(posedge pclk) disable iff (!presetn)
		ren & bus_ok & lads_evt & !gtl_evt |=> remote_q) else $error("listen with REN not remote");
	gtl_local_a: assert property (@(posedge pclk) disable iff (!presetn)
		ren & bus_ok & gtl_evt |=> !remote_q) else $error("GTL ignored");
	no_talk_local_a: assert property (@(posedge pclk) disable iff (!presetn)
		!remote_q |=> !out_valid || $past(tx_q) != gprc_pkg::TX_IDLE) else $error("sourced in local");
	lockout_esc_a: assert property (@(posedge pclk) disable iff (!presetn)
		llo_q & !prompt |=> !prompt) else $error("escape under lockout");
	lamp_late_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(llo_q) |-> !llo_lamp) else $error("lamp lit at once");
	prompt_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		ren & prompt & key_one |=> !remote_q & !prompt) else $error("key one not local");
	srq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		tacs_q |=> !srq) else $error("srq kept in talk");
	crlf_eoi_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_eoi |-> out_valid & out_byte == gprc_pkg::CHR_LF) else $error("EOI not on LF");
	revert_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_ok & unt_evt |=> mode_q == $past(base_q)) else $error("no revert on untalk");
	addr_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 own_addr <= gprc_pkg::ADDR_MAX) else $error("address out of range");
	done_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_q & tx_q == gprc_pkg::TX_IDLE |=> !out_valid) else $error("sent after completion");
endmodule

//--- tb_top.sv
/*
 * Self-checking bench for the remote/local and output-mode controller.
 * Assumes the controller model drives bus events and that front-panel
 * keys and the measurement trigger come from the bench itself.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 8;
	localparam logic [7:0] E_LADS = 8'h01;
	localparam logic [7:0] E_TADS = 8'h04;
	localparam logic [7:0] E_UNT = 8'h08;
	localparam logic [7:0] E_GET = 8'h10;
	localparam logic [7:0] E_GTL = 8'h20;
	localparam logic [7:0] E_LLO = 8'h40;
	localparam logic [7:0] E_RXD = 8'h80;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ren, atn, lads, unl, tads, unt, get, gtl, llo, rxd;
	logic [4:0] fp, nv_own_addr, nv_plot_addr, own_addr;
	logic nv_write, remote, llo_lamp, prompt, emulation, srq, abort_act;
	logic [7:0] out_byte;
	logic out_valid, out_eoi, out_ready, abort_seen;
	int miscompares, n_checks, nv_cnt;
	// ************
	// Instances
	// ************
	gprc_top #(.SELF_CHECK(SC)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ren(ren), .atn(atn), .lads_evt(lads),
		.unl_evt(unl), .tads_evt(tads), .unt_evt(unt), .get_evt(get), .gtl_evt(gtl),
		.llo_evt(llo), .rx_data_evt(rxd), .key_menu(fp[0]), .key_one(fp[1]),
		.key_two(fp[2]), .key_other(fp[3]), .meas_trig(fp[4]), .nv_own_addr(nv_own_addr),
		.nv_plot_addr(nv_plot_addr), .own_addr(own_addr), .nv_write(nv_write),
		.remote(remote), .llo_lamp(llo_lamp), .prompt(prompt), .emulation(emulation),
		.srq(srq), .abort_act(abort_act), .out_byte(out_byte), .out_valid(out_valid),
		.out_eoi(out_eoi), .out_ready(out_ready));
	gprc_ctrl_model ctl (.pclk(pclk), .ren(ren), .atn(atn), .lads_evt(lads),
		.unl_evt(unl), .tads_evt(tads), .unt_evt(unt), .get_evt(get), .gtl_evt(gtl),
		.llo_evt(llo), .rx_data_evt(rxd), .out_byte(out_byte), .out_valid(out_valid),
		.out_eoi(out_eoi), .out_ready(out_ready));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// One-cycle strobes are latched or counted for later checking.
	always @(posedge pclk) begin
		if (abort_act === 1'b1) abort_seen <= 1'b1;
		if (nv_write === 1'b1) nv_cnt <= nv_cnt + 1;
	end
	// ************
	// Helpers
	// ************
	task automatic close_out();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request is held until pready is sampled high; the task has no timeout of its own.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		repeat (2) @(posedge pclk);
	endtask
	task automatic chk_stat(input int b, input logic x);
		logic [31:0] q;
		rd(gprc_pkg::OFS_STAT, q);
		chk({31'h0, q[b]}, {31'h0, x});
	endtask
	task automatic chk_mode(input logic [2:0] m);
		logic [31:0] q;
		rd(gprc_pkg::OFS_STAT, q);
		chk({29'h0, q[10:8]}, {29'h0, m});
	endtask
	task automatic key(input logic [4:0] m);
		@(posedge pclk);
		fp <= m;
		@(posedge pclk);
		fp <= 5'h00;
		repeat (3) @(posedge pclk);
	endtask
	task automatic wait_bytes(input int n);
		int k;
		k = 0;
		while (ctl.rxq.size() < n && k < 200) begin
			@(posedge pclk);
			k++;
		end
		chk(ctl.rxq.size(), n);
	endtask
	// The self check lasts SC cycles; address stays at its default until then.
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(own_addr, 32'h4);
		repeat (SC + 3) @(posedge pclk);
	endtask
	// ************
	// Scenarios
	// ************
	task automatic t_power();
		logic [31:0] q;
		logic e;
		chk(own_addr, 32'h07);
		chk_mode(3'h0);
		rd(gprc_pkg::OFS_ADDR, q);
		chk(q & 32'h1F1F, 32'h0507);
		wr(gprc_pkg::OFS_CTRL, 32'h3);
		chk(emulation, 32'h1);
		do_reset();
		chk(emulation, 32'h0);
		wr(gprc_pkg::OFS_ADDR, 32'h1F1F);
		chk(own_addr, 32'h07);
		chk(nv_cnt, 32'h0);
		wr(gprc_pkg::OFS_ADDR, 32'h1E1E);
		chk(own_addr, 32'h1E);
		chk(nv_cnt, 32'h1);
		wr(gprc_pkg::OFS_ADDR, 32'h0000);
		chk(own_addr, 32'h00);
		apb(1'b0, 8'h14, 32'h0, q, e);
		chk(e, 32'h1);
		wr(gprc_pkg::OFS_CTRL, 32'h1);
	endtask
	// Addressed but not remote: errors are flagged and talking is refused.
	task automatic t_local();
		ctl.pulse(E_LADS);
		chk(remote, 32'h0);
		wr(gprc_pkg::OFS_CMD, 32'h11);
		chk_mode(3'h0);
		ctl.pulse(E_GET);
		chk_stat(7, 1'b1);
		chk(srq, 32'h1);
		wr(gprc_pkg::OFS_CMD, 32'h40);
		chk_stat(7, 1'b0);
		ctl.pulse(E_RXD);
		chk_stat(7, 1'b1);
		wr(gprc_pkg::OFS_CMD, 32'h40);
		ctl.pulse(E_TADS);
		ctl.lines(1'b0, 1'b0);
		chk_stat(3, 1'b0);
		wr(gprc_pkg::OFS_TXD, 32'h141);
		repeat (4) @(posedge pclk);
		chk(ctl.rxq.size(), 0);
		ctl.lines(1'b0, 1'b1);
		wr(gprc_pkg::OFS_CTRL, 32'h0);
		wr(gprc_pkg::OFS_CTRL, 32'h1);
	endtask
	task automatic t_remote();
		ctl.lines(1'b1, 1'b1);
		ctl.pulse(E_LADS);
		chk(remote, 32'h1);
		for (int m = 5; m >= 0; m--) begin
			wr(gprc_pkg::OFS_CMD, 32'h10 | m);
			chk_mode(m[2:0]);
		end
		ctl.pulse(E_GTL);
		chk(remote, 32'h0);
		ctl.pulse(E_LADS);
		chk(remote, 32'h1);
		ctl.lines(1'b0, 1'b1);
		chk(remote, 32'h0);
		ctl.lines(1'b1, 1'b1);
		ctl.pulse(E_LADS);
	endtask
	// Prompt blocks other keys and bus events until one of the soft keys.
	task automatic t_escape();
		key(5'h01);
		chk(prompt, 32'h1);
		key(5'h08);
		ctl.pulse(E_GTL);
		chk(remote, 32'h1);
		key(5'h04);
		chk({prompt, remote}, 32'h1);
		key(5'h01);
		key(5'h02);
		chk({prompt, remote}, 32'h0);
		ctl.pulse(E_LADS);
		chk(remote, 32'h1);
	endtask
	task automatic t_lockout();
		ctl.pulse(E_LLO);
		chk(llo_lamp, 32'h0);
		key(5'h08);
		chk(llo_lamp, 32'h1);
		key(5'h01);
		chk({prompt, remote}, 32'h1);
	endtask
	// Trigger reset, measurement, service request, then the ended string.
	task automatic t_trig();
		ctl.pulse(E_GET);
		chk_stat(4, 1'b1);
		key(5'h10);
		chk_stat(5, 1'b1);
		chk(srq, 32'h1);
		ctl.stall <= 1'b1;
		ctl.talk_read();
		chk(srq, 32'h0);
		wr(gprc_pkg::OFS_TXD, 32'h141);
		wait_bytes(3);
		chk(ctl.rxq[0], 32'h041);
		chk(ctl.rxq[1], {23'h0, 1'b0, gprc_pkg::CHR_CR});
		chk(ctl.rxq[2], {23'h0, 1'b1, gprc_pkg::CHR_LF});
		ctl.stall <= 1'b0;
		ctl.rxq.delete();
		wr(gprc_pkg::OFS_CMD, 32'h20);
		chk_stat(5, 1'b1);
	endtask
	task automatic t_selfterm();
		wr(gprc_pkg::OFS_CMD, 32'h11);
		wr(gprc_pkg::OFS_CMD, 32'h14);
		chk_mode(3'h4);
		wr(gprc_pkg::OFS_TXD, 32'h153);
		wait_bytes(3);
		chk_stat(6, 1'b1);
		wr(gprc_pkg::OFS_TXD, 32'h154);
		repeat (6) @(posedge pclk);
		chk(ctl.rxq.size(), 3);
		ctl.pulse(E_UNT);
		chk_mode(3'h1);
		ctl.lines(1'b1, 1'b1);
		wr(gprc_pkg::OFS_CMD, 32'h10);
		ctl.pulse(E_GET);
		ctl.pulse(E_TADS);
		ctl.pulse(E_UNT);
		chk(abort_seen, 32'h1);
		wr(gprc_pkg::OFS_CMD, 32'h15);
		ctl.rxq.delete();
		ctl.talk_read();
		wr(gprc_pkg::OFS_TXD, 32'h150);
		wait_bytes(3);
		chk_stat(3, 1'b0);
		chk_mode(3'h0);
		ctl.lines(1'b1, 1'b1);
	endtask
	// ************
	// Main sequence
	// ************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fp = 5'h00;
		nv_own_addr = 5'h07;
		nv_plot_addr = 5'h1F;
		abort_seen = 1'b0;
		miscompares = 0;
		n_checks = 0;
		nv_cnt = 0;
		do_reset();
		t_power();
		t_local();
		t_remote();
		t_escape();
		t_lockout();
		t_trig();
		t_selfterm();
		close_out();
	end
	// Far above the few hundred cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		close_out();
	end
endmodule
